// ==== sdram_cfg_consts.vh ====
`ifndef SDRAM_CFG_CONSTS_VH
`define SDRAM_CFG_CONSTS_VH
// Register byte addresses on the system bus
`define ADDR_TIMING_CONFIG 32'h10000000
`define ADDR_REFRESH_INTERVAL 32'h10000004
// Configuration field positions
`define CFG_PRECHARGE_BIT 30
`define CFG_MODE_ARM_BIT 29
`define CFG_REFRESH_BIT 28
`define CFG_LAT_HI 21
`define CFG_LAT_LO 20
`define CFG_ACT_RW_HI 17
`define CFG_ACT_RW_LO 16
`define CFG_REF_ACT_HI 15
`define CFG_REF_ACT_LO 12
`define CFG_RAS_HI 10
`define CFG_RAS_LO 8
`define CFG_WR_ACT_HI 6
`define CFG_WR_ACT_LO 4
`define CFG_RP_BIT 1
`define CFG_DPL_BIT 0
// Writable configuration bits (reserved bits read zero)
`define CFG_WRITE_MASK 32'h7033F773
`define CFG_RESET 32'h00000000
// DRAM area decode: address bits 31..26 zero
`define DRAM_AREA_MASK 32'hFC000000
// Mode value field on the system bus address
`define MODE_ADDR_HI 22
`define MODE_ADDR_LO 11
// Refresh timer width and reset
`define REF_W 11
`define REF_RESET 11'h000
`define REF_ONE 11'h001
`endif

// ==== sdram_config_refresh.v ====
`timescale 1ns/1ps
`include "sdram_cfg_consts.vh"
module sdram_config_refresh
(
    // Clock and reset
    input wire sys_clk_i,
    input wire rst_i,
    // System bus register and store access
    input wire bus_wr_i,
    input wire bus_rd_i,
    input wire [31:0] bus_addr_i,
    input wire [31:0] bus_wdata_i,
    output reg [31:0] bus_rdata_o,
    // Transaction engine status
    input wire dram_busy_i,
    // Commands to the SDRAM pin sequencer
    output reg cmd_precharge_o,
    output reg cmd_mode_set_o,
    output reg cmd_refresh_o,
    output reg [11:0] mode_value_o,
    input wire cmd_done_i,
    // Timing fields to the transaction engine
    output wire [1:0] read_latency_o,
    output wire [1:0] act_to_rw_delay_o,
    output wire [3:0] refresh_to_act_period_o,
    output wire [2:0] act_to_pre_period_o,
    output wire [2:0] wrdata_to_act_period_o,
    output wire [1:0] pre_to_act_cycles_o,
    output wire [1:0] wrdata_to_pre_cycles_o,
    // Store to DRAM area while mode-set is not armed
    output wire dram_store_o
);

    // Sequencer state codes
    localparam ST_IDLE = 2'h0;
    localparam ST_PRE = 2'h1;
    localparam ST_MODE = 2'h2;
    localparam ST_REF = 2'h3;

    // Bits that software may set in the configuration word
    localparam [31:0] CFG_WR_MASK = `CFG_WRITE_MASK;

    // Configuration register and its next value
    reg [31:0] cfg_r;
    reg [31:0] cfg_nxt;

    // Refresh interval, down-counter and run flag
    reg [`REF_W-1:0] interval_r;
    reg [`REF_W-1:0] interval_nxt;
    reg [`REF_W-1:0] count_r;
    reg [`REF_W-1:0] count_nxt;
    reg running_r;
    reg running_nxt;

    // Command sequencer state and captured mode value
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [11:0] mode_value_nxt;

    // Read data next value
    reg [31:0] rdata_nxt;

    // Counter at one, refresh due
    reg refresh_tick;

    // Decoded selects and strobes
    wire cfg_sel;
    wire int_sel;
    wire dram_sel;
    wire cfg_wr;
    wire int_wr;
    wire mode_store;
    wire pre_done;
    wire ref_done;
    wire seq_idle;
    wire [31:0] cfg_sw;
    wire [31:0] count_word;

    // Register and DRAM area decode
    assign cfg_sel = (bus_addr_i == `ADDR_TIMING_CONFIG);
    assign int_sel = (bus_addr_i == `ADDR_REFRESH_INTERVAL);
    assign dram_sel = ((bus_addr_i & `DRAM_AREA_MASK) == 32'h00000000);

    // Register write strobes
    assign cfg_wr = bus_wr_i && cfg_sel;
    assign int_wr = bus_wr_i && int_sel;

    // Armed store requests a mode-set, otherwise a plain store
    assign mode_store = bus_wr_i && dram_sel && cfg_r[`CFG_MODE_ARM_BIT];
    assign dram_store_o = bus_wr_i && dram_sel && !cfg_r[`CFG_MODE_ARM_BIT];

    // Sequencer free to take a new command
    assign seq_idle = (state_r == ST_IDLE);

    // Command completion seen per state
    assign pre_done = (state_r == ST_PRE) && cmd_done_i;
    assign ref_done = (state_r == ST_REF) && cmd_done_i;

    // Raw timing fields for the transaction engine
    assign read_latency_o = cfg_r[`CFG_LAT_HI:`CFG_LAT_LO];
    assign act_to_rw_delay_o = cfg_r[`CFG_ACT_RW_HI:`CFG_ACT_RW_LO];
    assign refresh_to_act_period_o = cfg_r[`CFG_REF_ACT_HI:`CFG_REF_ACT_LO];
    assign act_to_pre_period_o = cfg_r[`CFG_RAS_HI:`CFG_RAS_LO];
    assign wrdata_to_act_period_o = cfg_r[`CFG_WR_ACT_HI:`CFG_WR_ACT_LO];

    // Selected cycle counts from the single-bit fields
    assign pre_to_act_cycles_o = cfg_r[`CFG_RP_BIT] ? 2'h3 : 2'h2;
    assign wrdata_to_pre_cycles_o = cfg_r[`CFG_DPL_BIT] ? 2'h2 : 2'h1;

    // Counter value as a read word, upper bits zero
    assign count_word = {21'h00000, count_r};

    // Per-bit software write value, reserved bits forced to zero
    genvar b;
    generate
        for (b = 0; b < 32; b = b + 1)
        begin : g_cfg_bit
            assign cfg_sw[b] = CFG_WR_MASK[b] & bus_wdata_i[b];
        end
    endgenerate

    // Refresh counter reaching one requests refresh
    always @*
    begin
        refresh_tick = running_r && (count_r == `REF_ONE);
    end

    // Command sequencer next state, mode-set over precharge over refresh
    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
            begin
                if (!dram_busy_i)
                begin
                    if (mode_store)
                        state_nxt = ST_MODE;
                    else if (cfg_r[`CFG_PRECHARGE_BIT])
                        state_nxt = ST_PRE;
                    else if (cfg_r[`CFG_REFRESH_BIT])
                        state_nxt = ST_REF;
                end
            end
            default:
            begin
                if (cmd_done_i)
                    state_nxt = ST_IDLE;
            end
        endcase
    end

    // Mode value taken from the armed store address
    always @*
    begin
        mode_value_nxt = mode_value_o;
        if (seq_idle && state_nxt == ST_MODE)
            mode_value_nxt = bus_addr_i[`MODE_ADDR_HI:`MODE_ADDR_LO];
    end

    // Sequencer state
    always @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // Command outputs, high while the command is outstanding
    always @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cmd_precharge_o <= 1'b0;
            cmd_mode_set_o <= 1'b0;
            cmd_refresh_o <= 1'b0;
        end
        else
        begin
            cmd_precharge_o <= (state_nxt == ST_PRE);
            cmd_mode_set_o <= (state_nxt == ST_MODE);
            cmd_refresh_o <= (state_nxt == ST_REF);
        end
    end

    // Mode value register
    always @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            mode_value_o <= 12'h000;
        else
            mode_value_o <= mode_value_nxt;
    end

    // Configuration next value; hardware set wins over every clear
    always @*
    begin
        cfg_nxt = cfg_r;
        if (cfg_wr)
            cfg_nxt = cfg_sw;
        if (pre_done && !cfg_wr)
            cfg_nxt[`CFG_PRECHARGE_BIT] = 1'b0;
        if (ref_done && !cfg_wr)
            cfg_nxt[`CFG_REFRESH_BIT] = 1'b0;
        if (refresh_tick)
            cfg_nxt[`CFG_REFRESH_BIT] = 1'b1;
    end

    // Configuration register
    always @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            cfg_r <= `CFG_RESET;
        else
            cfg_r <= cfg_nxt;
    end

    // Refresh timer next values
    always @*
    begin
        interval_nxt = interval_r;
        count_nxt = count_r;
        running_nxt = running_r;
        if (int_wr)
        begin
            interval_nxt = bus_wdata_i[`REF_W-1:0];
            count_nxt = bus_wdata_i[`REF_W-1:0];
            running_nxt = 1'b1;
        end
        else if (running_r)
        begin
            if (count_r <= `REF_ONE)
                count_nxt = interval_r;
            else
                count_nxt = count_r - `REF_ONE;
        end
    end

    // Refresh timer registers; only a reset stops the counter
    always @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            interval_r <= `REF_RESET;
            count_r <= `REF_RESET;
            running_r <= 1'b0;
        end
        else
        begin
            interval_r <= interval_nxt;
            count_r <= count_nxt;
            running_r <= running_nxt;
        end
    end

    // Register read data next value
    always @*
    begin
        rdata_nxt = bus_rdata_o;
        if (bus_rd_i)
        begin
            if (cfg_sel)
                rdata_nxt = cfg_r;
            else if (int_sel)
                rdata_nxt = count_word;
            else
                rdata_nxt = 32'h00000000;
        end
    end

    // Register read data
    always @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            bus_rdata_o <= 32'h00000000;
        else
            bus_rdata_o <= rdata_nxt;
    end

endmodule

// ==== sdram_seq_model.sv ====
`timescale 1ns/1ps
module sdram_seq_model #(parameter int DLY = 2) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic busy_i,
    output logic done_o = 1'b0
);
    int n = 0;
    // Ends each command on the (DLY+1)th falling clock edge while busy
    always @(negedge clk_i)
    begin
        done_o <= 1'b0;
        n <= 0;
        if (busy_i && !rst_i && !done_o)
        begin
            n <= n + 1;
            if (n == DLY)
            begin
                done_o <= 1'b1;
                n <= 0;
            end
        end
    end
endmodule

// ==== sdram_config_refresh_monitor.sv ====
`timescale 1ns/1ps
module sdram_config_refresh_monitor (
    input wire sys_clk_i, rst_i, bus_wr_i, bus_rd_i, dram_busy_i, cmd_refresh_o, cmd_mode_set_o, cmd_done_i,
    input wire [31:0] bus_addr_i, bus_wdata_i, bus_rdata_o,
    input wire [11:0] mode_value_o,
    input wire [1:0] read_latency_o, act_to_rw_delay_o, pre_to_act_cycles_o, wrdata_to_pre_cycles_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    wire cfg_wr = bus_wr_i && bus_addr_i == 32'h10000000;
    // Fields follow the last configuration write
    a_lat_field: assert property (cfg_wr |=> read_latency_o == $past(bus_wdata_i[21:20]))
        else $error("latency field");
    a_act_rw_field: assert property (cfg_wr |=> act_to_rw_delay_o == $past(bus_wdata_i[17:16]))
        else $error("activate to command field");
    a_pre_select: assert property (cfg_wr |=> pre_to_act_cycles_o == ($past(bus_wdata_i[1]) ? 2'h3 : 2'h2))
        else $error("pre select");
    a_dpl_select: assert property (cfg_wr |=> wrdata_to_pre_cycles_o == ($past(bus_wdata_i[0]) ? 2'h2 : 2'h1))
        else $error("dpl select");
    // Commands and counter read
    a_mode_capture: assert property ($rose(cmd_mode_set_o) |-> mode_value_o == $past(bus_addr_i[22:11]))
        else $error("mode value");
    a_pend_busy: assert property ($rose(cmd_refresh_o) |-> !$past(dram_busy_i))
        else $error("refresh while busy");
    a_ref_clear: assert property (cmd_refresh_o && cmd_done_i |=> !cmd_refresh_o)
        else $error("refresh not cleared");
    a_rd_upper: assert property (bus_rd_i && bus_addr_i == 32'h10000004 |=> bus_rdata_o[31:11] == 21'h0)
        else $error("counter upper bits");
endmodule
bind sdram_config_refresh sdram_config_refresh_monitor i_mon (.*);

// ==== sdram_config_refresh_test.sv ====
`timescale 1ns/1ps
module sdram_config_refresh_test;
    reg sys_clk_i = 0, rst_i = 1, bus_wr_i = 0, bus_rd_i = 0, dram_busy_i = 0;
    reg [31:0] bus_addr_i = 0, bus_wdata_i = 0;
    wire [31:0] bus_rdata_o;
    wire cmd_precharge_o, cmd_mode_set_o, cmd_refresh_o, cmd_done_i, dram_store_o;
    wire [11:0] mode_value_o;
    wire [1:0] lat, act_rw, pre, dpl;
    wire [3:0] ref_act;
    wire [2:0] ras, wr_act;
    wire [2:0] cmds = {cmd_refresh_o, cmd_mode_set_o, cmd_precharge_o};
    int n_fail = 0, samples_checked = 0, i;
    time t0;
    sdram_config_refresh i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
        .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o), .dram_busy_i(dram_busy_i),
        .cmd_precharge_o(cmd_precharge_o), .cmd_mode_set_o(cmd_mode_set_o), .cmd_refresh_o(cmd_refresh_o),
        .mode_value_o(mode_value_o), .cmd_done_i(cmd_done_i), .read_latency_o(lat), .act_to_rw_delay_o(act_rw),
        .refresh_to_act_period_o(ref_act), .act_to_pre_period_o(ras), .wrdata_to_act_period_o(wr_act),
        .pre_to_act_cycles_o(pre), .wrdata_to_pre_cycles_o(dpl), .dram_store_o(dram_store_o));
    sdram_seq_model i_seq (.clk_i(sys_clk_i), .rst_i(rst_i), .busy_i(|cmds), .done_o(cmd_done_i));
    initial forever #50 sys_clk_i = ~sys_clk_i;
    task end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input [31:0] got, exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // Bus write, checking the plain-store flag
    task wr(input [31:0] a, d, input s = 0);
        @(negedge sys_clk_i);
        bus_wr_i = 1;
        bus_addr_i = a;
        bus_wdata_i = d;
        #1 chk(dram_store_o, s);
        @(negedge sys_clk_i);
        bus_wr_i = 0;
    endtask
    task rd(input [31:0] a, exp);
        @(negedge sys_clk_i);
        bus_rd_i = 1;
        bus_addr_i = a;
        @(negedge sys_clk_i);
        bus_rd_i = 0;
        chk(bus_rdata_o, exp);
    endtask
    // Bounded wait for a command level
    task wt(input int s, input v);
        for (i = 0; i < 50 && cmds[s] !== v; i++) @(negedge sys_clk_i);
        if (i == 50)
        begin
            n_fail++;
            end_of_test;
        end
    endtask
    initial
    begin
        repeat (3) @(negedge sys_clk_i);
        rst_i = 0;
        rd(32'h10000000, 0);
        rd(32'h10000004, 0);
        wr(32'h10000000, 32'h8FFFFFFF);
        rd(32'h10000000, 32'h0033F773);
        chk({lat, act_rw, ref_act, ras, wr_act, pre, dpl}, {2'h3, 2'h3, 4'hF, 3'h7, 3'h7, 2'h3, 2'h2});
        wr(32'h10000000, 32'h00212532);
        chk({lat, act_rw, ref_act, ras, wr_act, pre, dpl}, {2'h2, 2'h1, 4'h2, 3'h5, 3'h3, 2'h3, 2'h1});
        $display("fields test done");
        wr(32'h10000000, 32'h40212532);
        wt(0, 1);
        wt(0, 0);
        rd(32'h10000000, 32'h00212532);
        dram_busy_i = 1;
        wr(32'h10000000, 32'h10212532);
        repeat (4) @(negedge sys_clk_i);
        chk(cmd_refresh_o, 0);
        dram_busy_i = 0;
        wt(2, 1);
        wt(2, 0);
        rd(32'h10000000, 32'h00212532);
        $display("command test done");
        for (int k = 1; k < 4; k++)
        begin
            wr(32'h10000000, 32'h20212532);
            wr(32'h00100000 | (k << 15), 0);
            wt(1, 1);
            chk(mode_value_o, 12'h200 | (k << 4));
            wt(1, 0);
        end
        wr(32'h10000000, 32'h00212532);
        wr(32'h00200000, 0, 1);
        $display("mode test done");
        wr(32'h10000004, 10);
        rd(32'h10000004, 9);
        wt(2, 1);
        t0 = $time;
        wt(2, 0);
        wt(2, 1);
        chk(($time - t0) / 100, 10);
        $display("timer test done");
        end_of_test;
    end
endmodule
